// File: rtl/lcd_display_control_timing.sv
// Display timing, drive sequencing and pixel overrides for a passive matrix LCD
`timescale 1ns/10ps
`default_nettype none

module lcd_display_control_timing (
  input  wire  logic                         clk_i,        // 20 MHz internal clock
  input  wire  logic                         rst_n_i,      // Async reset, active low
  input  wire  logic [3:0]                   addr_i,       // Register address
  input  wire  logic [15:0]                  wdata_i,      // Write data
  input  wire  logic                         wr_i,         // Write strobe
  input  wire  logic                         rd_i,         // Read strobe
  output logic [15:0]                        rdata_o,      // Read data, one cycle later
  input  wire  logic [1:0]                   pixel_i,      // Memory pixel for current row
  output logic [6:0]                         mem_row_o,    // Memory row being fetched
  output logic [1:0]                         col_level_o,  // Column drive level
  output logic                               col_gnd_o,    // Columns tied to ground
  output lcd_timing_pkg::row_drive_type      row_drive_o,  // Row electrode drive
  output lcd_timing_pkg::analog_ctrl_type    analog_o,     // Supply generator settings
  output logic                               line_tick_o,  // Line start pulse
  output logic                               frame_tick_o, // Frame start pulse
  output logic [1:0]                         gray_phase_o  // Modulation phase
);

  // Configuration registers
  logic [9:0] panel_control_word_q;
  logic [2:0] display_control_word_q;
  logic [3:0] power_control_word_q;
  logic [1:0] bias_ratio_select_q;
  logic [1:0] temp_coeff_select_q;
  logic [6:0] com_end_index_q;
  logic [6:0] display_start_row_q;
  logic [6:0] display_end_row_q;
  logic [6:0] scroll_line_offset_q;
  logic [3:0] fixed_region_top_q;
  logic [3:0] fixed_region_bottom_q;

  // Timing state
  lcd_timing_pkg::seq_state_type seq_q, seq_d;
  logic [11:0] seq_cnt_q;
  logic [11:0] line_cnt_q;
  logic [6:0]  row_q;
  logic [1:0]  gray_q;
  logic [15:0] rdata_q;

  // Mux rate: in partial mode, count of rows from start to end, plus fixed rows; otherwise com end index plus one
  function automatic logic [7:0] span(input logic [6:0] a, input logic [6:0] b);
    span = (b >= a) ? 8'({1'b0, b} - {1'b0, a} + 8'd1) : 8'd1;
  endfunction

  wire [1:0] part_field   = panel_control_word_q[lcd_timing_pkg::PCW_PART_LO +: 2];
  wire       fixed_en     = panel_control_word_q[lcd_timing_pkg::PCW_FIXED_EN_BIT];
  wire [7:0] fixed_rows   = 8'({fixed_region_top_q, 1'b0}) + 8'({fixed_region_bottom_q, 1'b0});
  wire [7:0] full_mux     = 8'({1'b0, com_end_index_q} + 8'd1);
  wire [7:0] part_mux     = span(display_start_row_q, display_end_row_q)
                            + (fixed_en ? fixed_rows : 8'd0);
  wire [7:0] mux_rate     = (part_field == 2'b11) ? part_mux : full_mux;

  // base line period from line rate code
  wire [1:0]  line_sel    = panel_control_word_q[lcd_timing_pkg::PCW_LINE_LO +: 2];
  wire [11:0] base_per    = (line_sel == 2'd0) ? lcd_timing_pkg::LINE_PER_0 :
                            (line_sel == 2'd1) ? lcd_timing_pkg::LINE_PER_1 :
                            (line_sel == 2'd2) ? lcd_timing_pkg::LINE_PER_2 :
                                                 lcd_timing_pkg::LINE_PER_3;
  // slow line rate at low mux
  wire [13:0] per_x15     = 14'({2'b00, base_per} + 14'({3'b000, base_per[11:1]}));
  wire [13:0] per_x2      = 14'({base_per, 1'b0});
  wire [13:0] per_x3      = 14'({base_per, 1'b0}) + 14'({2'b00, base_per});
  wire [13:0] per_x4      = 14'({base_per, 2'b00});
  wire [13:0] eff_per     = (mux_rate <= lcd_timing_pkg::MUX_32) ? per_x4 :
                            (mux_rate <= lcd_timing_pkg::MUX_43) ? per_x3 :
                            (mux_rate <= lcd_timing_pkg::MUX_64) ? per_x2 :
                            (mux_rate <= lcd_timing_pkg::MUX_85) ? per_x15 :
                                                                   {2'b00, base_per};
  wire [11:0] line_per    = (eff_per > 14'h0fff) ? 12'hfff : eff_per[11:0];

  // Register decode
  wire wr_panel = wr_i && (addr_i == lcd_timing_pkg::ADDR_PANEL_CTRL);
  wire wr_disp  = wr_i && (addr_i == lcd_timing_pkg::ADDR_DISP_CTRL);
  wire wr_power = wr_i && (addr_i == lcd_timing_pkg::ADDR_POWER_CTRL);
  wire wr_bt    = wr_i && (addr_i == lcd_timing_pkg::ADDR_BIAS_TEMP);
  wire wr_cend  = wr_i && (addr_i == lcd_timing_pkg::ADDR_COM_END);
  wire wr_dst   = wr_i && (addr_i == lcd_timing_pkg::ADDR_DISP_START);
  wire wr_dend  = wr_i && (addr_i == lcd_timing_pkg::ADDR_DISP_END);
  wire wr_scr   = wr_i && (addr_i == lcd_timing_pkg::ADDR_SCROLL);
  wire wr_fix   = wr_i && (addr_i == lcd_timing_pkg::ADDR_FIXED);

  wire enable   = display_control_word_q[lcd_timing_pkg::DCW_EN_BIT];
  wire all_pixels_force      = display_control_word_q[lcd_timing_pkg::DCW_APO_BIT];
  wire inv      = display_control_word_q[lcd_timing_pkg::DCW_INV_BIT];
  wire active   = (seq_q == lcd_timing_pkg::SEQ_ACTIVE);

  // Read mux; unmapped addresses read zero
  wire [15:0] rd_val =
    (addr_i == lcd_timing_pkg::ADDR_PANEL_CTRL) ? {6'h00, panel_control_word_q} :
    (addr_i == lcd_timing_pkg::ADDR_DISP_CTRL)  ? {13'h0000, display_control_word_q} :
    (addr_i == lcd_timing_pkg::ADDR_POWER_CTRL) ? {12'h000, power_control_word_q} :
    (addr_i == lcd_timing_pkg::ADDR_BIAS_TEMP)  ? {12'h000, temp_coeff_select_q,
                                                   bias_ratio_select_q} :
    (addr_i == lcd_timing_pkg::ADDR_COM_END)    ? {9'h000, com_end_index_q} :
    (addr_i == lcd_timing_pkg::ADDR_DISP_START) ? {9'h000, display_start_row_q} :
    (addr_i == lcd_timing_pkg::ADDR_DISP_END)   ? {9'h000, display_end_row_q} :
    (addr_i == lcd_timing_pkg::ADDR_SCROLL)     ? {9'h000, scroll_line_offset_q} :
    (addr_i == lcd_timing_pkg::ADDR_FIXED)      ? {8'h00, fixed_region_bottom_q,
                                                   fixed_region_top_q} :
    (addr_i == lcd_timing_pkg::ADDR_STATUS)     ? {14'h0000, seq_q} :
    (addr_i == lcd_timing_pkg::ADDR_MUX_RATE)   ? {8'h00, mux_rate} :
    (addr_i == lcd_timing_pkg::ADDR_PIXEL)      ? {9'h000, row_q} :
                                                  16'h0000;

  // Configuration register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      panel_control_word_q   <= lcd_timing_pkg::PANEL_CTRL_RST;
      display_control_word_q <= lcd_timing_pkg::DISP_CTRL_RST;
      power_control_word_q   <= lcd_timing_pkg::POWER_CTRL_RST;
      bias_ratio_select_q    <= 2'h0;
      temp_coeff_select_q    <= 2'h0;
      com_end_index_q        <= lcd_timing_pkg::COM_END_RST;
      display_start_row_q    <= 7'h00;
      display_end_row_q      <= lcd_timing_pkg::DISP_END_RST;
      scroll_line_offset_q   <= 7'h00;
      fixed_region_top_q     <= 4'h0;
      fixed_region_bottom_q  <= 4'h0;
    end else begin
      if (wr_panel) panel_control_word_q   <= wdata_i[9:0];
      if (wr_disp)  display_control_word_q <= wdata_i[2:0];
      if (wr_power) power_control_word_q   <= wdata_i[3:0];
      if (wr_bt)    {temp_coeff_select_q, bias_ratio_select_q} <= wdata_i[3:0];
      if (wr_cend)  com_end_index_q        <= wdata_i[6:0];
      if (wr_dst)   display_start_row_q    <= wdata_i[6:0];
      if (wr_dend)  display_end_row_q      <= wdata_i[6:0];
      if (wr_scr)   scroll_line_offset_q   <= wdata_i[6:0];
      if (wr_fix)   {fixed_region_bottom_q, fixed_region_top_q} <= wdata_i[7:0];
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_i ? rd_val : 16'h0000;
    end
  end

  // Drive sequencer next state
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      lcd_timing_pkg::SEQ_SLEEP:  if (enable) seq_d = lcd_timing_pkg::SEQ_WAKE;
      lcd_timing_pkg::SEQ_WAKE:   if (!enable) seq_d = lcd_timing_pkg::SEQ_SLEEP;
                                  else if (seq_cnt_q == 12'h000) seq_d = lcd_timing_pkg::SEQ_SUPPLY;
      lcd_timing_pkg::SEQ_SUPPLY: if (!enable) seq_d = lcd_timing_pkg::SEQ_SLEEP;
                                  else if (seq_cnt_q == 12'h000) seq_d = lcd_timing_pkg::SEQ_ACTIVE;
      lcd_timing_pkg::SEQ_ACTIVE: if (!enable) seq_d = lcd_timing_pkg::SEQ_SLEEP;
      default:                    seq_d = lcd_timing_pkg::SEQ_SLEEP;
    endcase
  end

  // Sequencer state and phase counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_q     <= lcd_timing_pkg::SEQ_SLEEP;
      seq_cnt_q <= 12'h000;
    end else begin
      seq_q <= seq_d;
      if (seq_d == lcd_timing_pkg::SEQ_WAKE && seq_q != lcd_timing_pkg::SEQ_WAKE)
        seq_cnt_q <= lcd_timing_pkg::WAKE_CYC - 12'd1;
      else if (seq_d == lcd_timing_pkg::SEQ_SUPPLY && seq_q != lcd_timing_pkg::SEQ_SUPPLY)
        seq_cnt_q <= lcd_timing_pkg::SUPPLY_CYC - 12'd1;
      else if (seq_cnt_q != 12'h000)
        seq_cnt_q <= seq_cnt_q - 12'd1;
    end
  end

  // line timer runs from the internal clock
  wire line_end  = (line_cnt_q == 12'h000);
  wire [6:0] last_row = 7'(mux_rate - 8'd1);
  wire frame_end = line_end && (row_q >= last_row);

  // Line and row counters, gray modulation phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt_q <= 12'h000;
      row_q      <= 7'h00;
      gray_q     <= 2'h0;
    end else if (!active) begin
      line_cnt_q <= 12'h000;
      row_q      <= 7'h00;
      gray_q     <= 2'h0;
    end else if (line_end) begin
      line_cnt_q <= line_per - 12'd1;
      row_q      <= frame_end ? 7'h00 : row_q + 7'd1;
      if (frame_end) gray_q <= gray_q + 2'd1;
    end else begin
      line_cnt_q <= line_cnt_q - 12'd1;
    end
  end

  // start row offset picks electrode in partial mode, memory row follows electrode plus scroll outside the fixed regions
  wire [6:0] electrode = (part_field == 2'b11) ? 7'(display_start_row_q + row_q) : row_q;
  wire       in_range  = (electrode <= com_end_index_q);
  wire       in_top    = fixed_en && ({3'b000, fixed_region_top_q} > electrode);
  wire       in_bot    = fixed_en && (electrode > 7'(7'd127 - {3'b000, fixed_region_bottom_q}));
  wire [6:0] mem_row   = (in_top || in_bot) ? electrode : 7'(electrode + scroll_line_offset_q);

  // gray placement from bits 7:5 against modulation phase
  wire [2:0] gray_pos  = panel_control_word_q[lcd_timing_pkg::PCW_GRAY_LO +: 3];
  wire       light_on  = (gray_q < gray_pos[1:0]);
  wire       dark_on   = (gray_q != 2'd3) || gray_pos[2];
  wire [1:0] shaded    = (pixel_i == 2'd1) ? {1'b0, light_on} :
                         (pixel_i == 2'd2) ? {dark_on, 1'b0} : pixel_i;
  wire [1:0] inv_px    = inv ? ~shaded : shaded;
  wire [1:0] col_lvl   = !active ? 2'b00 : (all_pixels_force ? 2'b11 : inv_px);

  // Bias ratio and temperature coefficient lookups
  // bias mapping
  wire [3:0] bias_val  = (bias_ratio_select_q == 2'd0) ? lcd_timing_pkg::BIAS_0 :
                         (bias_ratio_select_q == 2'd1) ? lcd_timing_pkg::BIAS_1 :
                         (bias_ratio_select_q == 2'd2) ? lcd_timing_pkg::BIAS_2 :
                                                         lcd_timing_pkg::BIAS_3;
  wire signed [7:0] tc_val = (temp_coeff_select_q == 2'd0) ? lcd_timing_pkg::TCOEF_0 :
                             (temp_coeff_select_q == 2'd1) ? lcd_timing_pkg::TCOEF_1 :
                             (temp_coeff_select_q == 2'd2) ? lcd_timing_pkg::TCOEF_2 :
                                                             lcd_timing_pkg::TCOEF_3;
  wire [1:0] src_sel   = power_control_word_q[lcd_timing_pkg::PWR_SRC_LO +: 2];

  // Registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_level_o  <= 2'b00;
      col_gnd_o    <= 1'b1;
      row_drive_o  <= '{row: 7'h00, active: 1'b0, hiz: 1'b1};
      analog_o     <= '{bias_ratio: 4'h0, temp_coeff: 8'sd0, ext_supply: 1'b0,
                        pump_on: 1'b0, sleep: 1'b1};
      line_tick_o  <= 1'b0;
      frame_tick_o <= 1'b0;
      gray_phase_o <= 2'h0;
      mem_row_o    <= 7'h00;
    end else begin
      col_level_o  <= col_lvl;
      col_gnd_o    <= !active;
      // electrode index is the scanned row, plus start row offset in partial mode
      row_drive_o  <= '{row: electrode, active: active && in_range, hiz: !active};
      analog_o     <= '{bias_ratio: bias_val, temp_coeff: tc_val,
                        ext_supply: (src_sel == 2'b00),
                        pump_on: (src_sel != 2'b00) && (seq_q != lcd_timing_pkg::SEQ_SLEEP)
                                 && (seq_q != lcd_timing_pkg::SEQ_WAKE),
                        sleep: (seq_q == lcd_timing_pkg::SEQ_SLEEP)};
      line_tick_o  <= active && line_end;
      frame_tick_o <= active && frame_end;
      gray_phase_o <= gray_q;
      mem_row_o    <= mem_row;
    end
  end

  assign rdata_o = rdata_q;

endmodule // lcd_display_control_timing

`default_nettype wire

// File: include/lcd_timing_pkg.sv
// Package: constants and carriers for the display timing block
package lcd_timing_pkg;

  // Register port map (word addresses)
  localparam logic [3:0] ADDR_PANEL_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_DISP_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_POWER_CTRL  = 4'h2;
  localparam logic [3:0] ADDR_BIAS_TEMP   = 4'h3;
  localparam logic [3:0] ADDR_COM_END     = 4'h4;
  localparam logic [3:0] ADDR_DISP_START  = 4'h5;
  localparam logic [3:0] ADDR_DISP_END    = 4'h6;
  localparam logic [3:0] ADDR_SCROLL      = 4'h7;
  localparam logic [3:0] ADDR_FIXED       = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'h9;
  localparam logic [3:0] ADDR_MUX_RATE    = 4'ha;
  localparam logic [3:0] ADDR_PIXEL       = 4'hb;

  // Field positions
  localparam int PCW_FIXED_EN_BIT = 0;
  localparam int PCW_LINE_LO      = 3;
  localparam int PCW_GRAY_LO      = 5;
  localparam int PCW_PART_LO      = 8;
  localparam int DCW_INV_BIT      = 0;
  localparam int DCW_APO_BIT      = 1;
  localparam int DCW_EN_BIT       = 2;
  localparam int PWR_SRC_LO       = 2;

  // Reset values
  localparam logic [9:0] PANEL_CTRL_RST = 10'h000;
  localparam logic [2:0] DISP_CTRL_RST  = 3'h0;
  localparam logic [3:0] POWER_CTRL_RST = 4'h0;
  localparam logic [6:0] COM_END_RST    = 7'h7f;
  localparam logic [6:0] DISP_END_RST   = 7'h7f;

  // Mux thresholds for line rate scaling
  localparam logic [7:0] MUX_HI  = 8'd86;
  localparam logic [7:0] MUX_85  = 8'd85;
  localparam logic [7:0] MUX_64  = 8'd64;
  localparam logic [7:0] MUX_43  = 8'd43;
  localparam logic [7:0] MUX_32  = 8'd32;
  localparam logic [7:0] ROW_COUNT = 8'd128;

  // Base line periods in clk cycles, one per line rate code
  localparam logic [11:0] LINE_PER_0 = 12'd600;
  localparam logic [11:0] LINE_PER_1 = 12'd480;
  localparam logic [11:0] LINE_PER_2 = 12'd400;
  localparam logic [11:0] LINE_PER_3 = 12'd320;

  // Power-up sequence times and counts at 20 MHz
  localparam int CLK_MHZ        = 20;
  localparam int WAKE_US        = 10;
  localparam int SUPPLY_US      = 100;
  localparam logic [11:0] WAKE_CYC   = 12'(WAKE_US * CLK_MHZ);
  localparam logic [11:0] SUPPLY_CYC = 12'(SUPPLY_US * CLK_MHZ);

  // Bias ratio values and temperature coefficients (hundredths of %/C)
  localparam logic [3:0] BIAS_0 = 4'd6;
  localparam logic [3:0] BIAS_1 = 4'd9;
  localparam logic [3:0] BIAS_2 = 4'd10;
  localparam logic [3:0] BIAS_3 = 4'd11;
  localparam logic signed [7:0] TCOEF_0 = 8'sd0;
  localparam logic signed [7:0] TCOEF_1 = -8'sd10;
  localparam logic signed [7:0] TCOEF_2 = -8'sd15;
  localparam logic signed [7:0] TCOEF_3 = -8'sd5;

  // Drive sequencing states, Gray coded
  typedef enum logic [1:0] {
    SEQ_SLEEP  = 2'b00,
    SEQ_WAKE   = 2'b01,
    SEQ_SUPPLY = 2'b11,
    SEQ_ACTIVE = 2'b10
  } seq_state_type;

  // Analog settings handed to the supply generator
  typedef struct packed {
    logic [3:0]        bias_ratio;
    logic signed [7:0] temp_coeff;
    logic              ext_supply;
    logic              pump_on;
    logic              sleep;
  } analog_ctrl_type;

  // Per-row drive to the row electrode stage
  typedef struct packed {
    logic [6:0] row;
    logic       active;
    logic       hiz;
  } row_drive_type;

endpackage : lcd_timing_pkg

// File: tb/lcd_display_control_timing_assertions.sv
// Port assertions for the display timing block
`timescale 1ns/10ps
`default_nettype none
module lcd_display_control_timing_checker (
  input wire logic                            clk_i,        // Clock
  input wire logic                            rst_n_i,      // Reset
  input wire logic [3:0]                      addr_i,       // Address
  input wire logic [15:0]                     wdata_i,      // Write data
  input wire logic                            wr_i,         // Write strobe
  input wire logic                            rd_i,         // Read strobe
  input wire logic [15:0]                     rdata_o,      // Read data
  input wire logic [1:0]                      pixel_i,      // Pixel
  input wire logic [6:0]                      mem_row_o,    // Memory row
  input wire logic [1:0]                      col_level_o,  // Column level
  input wire logic                            col_gnd_o,    // Columns grounded
  input wire lcd_timing_pkg::row_drive_type   row_drive_o,  // Row drive
  input wire lcd_timing_pkg::analog_ctrl_type analog_o,     // Supply settings
  input wire logic                            line_tick_o,  // Line pulse
  input wire logic                            frame_tick_o, // Frame pulse
  input wire logic [1:0]                      gray_phase_o  // Gray phase
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_read_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
  property p_idle_cols; col_gnd_o |-> col_level_o == 2'h0; endproperty
  a_idle_cols: assert property (p_idle_cols) else $error("grounded columns driven");
  property p_rows_cols; col_gnd_o == row_drive_o.hiz; endproperty
  a_rows_cols: assert property (p_rows_cols) else $error("rows and columns disagree");
  property p_sleep_idle; analog_o.sleep |-> row_drive_o.hiz && col_gnd_o; endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("drivers on while asleep");
  property p_off_sleeps;
    wr_i && addr_i == lcd_timing_pkg::ADDR_DISP_CTRL && !wdata_i[2] |-> ##[1:3] analog_o.sleep;
  endproperty
  a_off_sleeps: assert property (p_off_sleeps) else $error("no sleep after disable");
  property p_on_wakes;
    wr_i && addr_i == lcd_timing_pkg::ADDR_DISP_CTRL && wdata_i[2] && analog_o.sleep
      |-> ##[1:3] !analog_o.sleep;
  endproperty
  a_on_wakes: assert property (p_on_wakes) else $error("no wake after enable");
  property p_supply_first; $fell(analog_o.sleep) |-> row_drive_o.hiz [*8]; endproperty
  a_supply_first: assert property (p_supply_first) else $error("drivers before supply");
  property p_one_source; !(analog_o.ext_supply && analog_o.pump_on); endproperty
  a_one_source: assert property (p_one_source) else $error("two supply sources");
  property p_line_pulse; line_tick_o |=> !line_tick_o; endproperty
  a_line_pulse: assert property (p_line_pulse) else $error("line pulse too long");
  property p_frame_line; frame_tick_o |-> line_tick_o; endproperty
  a_frame_line: assert property (p_frame_line) else $error("frame pulse off line");
  property p_gray_step;
    frame_tick_o |=> gray_phase_o == 2'($past(gray_phase_o) + 2'd1);
  endproperty
  a_gray_step: assert property (p_gray_step) else $error("gray phase not stepped");
endmodule // lcd_display_control_timing_checker

bind lcd_display_control_timing lcd_display_control_timing_checker checker_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .pixel_i(pixel_i), .mem_row_o(mem_row_o),
  .col_level_o(col_level_o), .col_gnd_o(col_gnd_o), .row_drive_o(row_drive_o),
  .analog_o(analog_o), .line_tick_o(line_tick_o), .frame_tick_o(frame_tick_o),
  .gray_phase_o(gray_phase_o));
`default_nettype wire

// File: tb/lcd_panel_model.sv
// Panel electrodes with a uniform pixel memory behind them
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model (
  input  wire logic                          clk_i,       // Clock
  input  wire logic                          rst_n_i,     // Reset
  input  wire logic [1:0]                    fill_i,      // Memory pattern
  input  wire logic [6:0]                    mem_row_i,   // Row fetched
  input  wire logic [1:0]                    col_level_i, // Column level
  input  wire logic                          col_gnd_i,   // Columns grounded
  input  wire lcd_timing_pkg::row_drive_type row_drive_i, // Row drive
  output logic [1:0]                         pixel_o,     // Pixel to device
  output logic [7:0]                         faults_o     // Electrode faults
);
  assign pixel_o = (mem_row_i <= 7'h7f) ? fill_i : ~fill_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      faults_o <= 8'h00;
    end else if (col_gnd_i && col_level_i != 2'h0 && row_drive_i.hiz) begin
      faults_o <= faults_o + 8'h01;
    end
  end
endmodule // lcd_panel_model
`default_nettype wire

// File: tb/lcd_display_control_timing_bench.sv
// Self-checking bench for the display timing block
`timescale 1ns/10ps
`default_nettype none
module lcd_display_control_timing_bench;
  logic        clk_i, rst_n_i, wr_i, rd_i, col_gnd_o, line_tick_o, frame_tick_o;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, rd_val;
  logic [1:0]  pixel_i, col_level_o, gray_phase_o, fill;
  logic [6:0]  mem_row_o;
  logic [7:0]  panel_faults;
  lcd_timing_pkg::row_drive_type   row_drive_o;
  lcd_timing_pkg::analog_ctrl_type analog_o;
  int          err_total, samples_checked, cycles, n;
  logic [11:0] per_exp [4];
  logic [3:0]  bias_exp [4];
  logic [7:0]  tc_exp [4];
  logic [1:0]  ovr_fill [4] = '{2'h3, 2'h3, 2'h0, 2'h0};
  logic [2:0]  ovr_disp [4] = '{3'h4, 3'h5, 3'h5, 3'h6};
  logic [1:0]  ovr_exp [4] = '{2'h3, 2'h0, 2'h3, 2'h3};

  lcd_display_control_timing lcd_display_control_timing_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pixel_i(pixel_i), .mem_row_o(mem_row_o),
    .col_level_o(col_level_o), .col_gnd_o(col_gnd_o), .row_drive_o(row_drive_o),
    .analog_o(analog_o), .line_tick_o(line_tick_o), .frame_tick_o(frame_tick_o),
    .gray_phase_o(gray_phase_o));
  lcd_panel_model lcd_panel_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fill_i(fill), .mem_row_i(mem_row_o),
    .col_level_i(col_level_o), .col_gnd_i(col_gnd_o), .row_drive_i(row_drive_o),
    .pixel_o(pixel_i), .faults_o(panel_faults));

  // Clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Register read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    rd_val = rdata_o;
  endtask

  // Poll the sequencer state
  task automatic wait_status(input logic [1:0] st, input int limit);
    int k;
    k = 0;
    do begin
      rd_reg(lcd_timing_pkg::ADDR_STATUS);
      k++;
    end while (rd_val !== {14'h0000, st} && k < limit);
    check(rd_val, {14'h0000, st}, "sequencer state");
  endtask

  // Cycles up to the next line pulse
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (line_tick_o !== 1'b1 && cnt < 6000);
    if (cnt >= 6000) check(16'h0000, 16'h0001, "line pulse missing");
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run length guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      $display("ERROR at %0t: run too long", $time);
      complete_run();
    end
  end

  // Test sequence
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    fill = 2'h3;
    per_exp = '{lcd_timing_pkg::LINE_PER_0, lcd_timing_pkg::LINE_PER_1,
                lcd_timing_pkg::LINE_PER_2, lcd_timing_pkg::LINE_PER_3};
    bias_exp = '{lcd_timing_pkg::BIAS_0, lcd_timing_pkg::BIAS_1,
                 lcd_timing_pkg::BIAS_2, lcd_timing_pkg::BIAS_3};
    tc_exp = '{lcd_timing_pkg::TCOEF_0, lcd_timing_pkg::TCOEF_1,
               lcd_timing_pkg::TCOEF_2, lcd_timing_pkg::TCOEF_3};
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    wr_reg(4'hc, 16'hffff);
    for (int i = 0; i < 16; i++) begin
      if (i != 10 && i != 11) begin
        rd_reg(4'(i));
        check(rd_val, (i == 4 || i == 6) ? 16'h007f : 16'h0000, "reset value");
      end
    end
    $display("Reset values test done");
    wr_reg(lcd_timing_pkg::ADDR_DISP_CTRL, 16'hfffb);
    rd_reg(lcd_timing_pkg::ADDR_DISP_CTRL);
    check(rd_val, 16'h0003, "display control");
    check({14'h0000, col_gnd_o, row_drive_o.hiz}, 16'h0003, "drivers idle");
    wr_reg(lcd_timing_pkg::ADDR_POWER_CTRL, 16'hfff3);
    check({15'h0000, analog_o.ext_supply}, 16'h0001, "external supply");
    wr_reg(lcd_timing_pkg::ADDR_POWER_CTRL, 16'h0004);
    check({15'h0000, analog_o.ext_supply}, 16'h0000, "pump supply");
    for (int c = 0; c < 4; c++) begin
      wr_reg(lcd_timing_pkg::ADDR_BIAS_TEMP, 16'(c * 5));
      @(posedge clk_i);
      check({12'h000, analog_o.bias_ratio}, {12'h000, bias_exp[c]}, "bias ratio");
      check({8'h00, analog_o.temp_coeff}, {8'h00, tc_exp[c]}, "temp coefficient");
    end
    $display("Settings test done");
    wr_reg(lcd_timing_pkg::ADDR_DISP_START, 16'h000a);
    wr_reg(lcd_timing_pkg::ADDR_DISP_END, 16'h0028);
    wr_reg(lcd_timing_pkg::ADDR_FIXED, 16'h0032);
    wr_reg(lcd_timing_pkg::ADDR_PANEL_CTRL, 16'h0301);
    rd_reg(lcd_timing_pkg::ADDR_MUX_RATE);
    check(rd_val, 16'h0029, "mux with fixed rows");
    wr_reg(lcd_timing_pkg::ADDR_PANEL_CTRL, 16'h0300);
    rd_reg(lcd_timing_pkg::ADDR_MUX_RATE);
    check(rd_val, 16'h001f, "mux without fixed rows");
    wr_reg(lcd_timing_pkg::ADDR_DISP_CTRL, 16'h0004);
    wait_status(lcd_timing_pkg::SEQ_WAKE, 10);
    check({15'h0000, analog_o.sleep}, 16'h0000, "sleep left");
    wait_status(lcd_timing_pkg::SEQ_SUPPLY, 400);
    check({15'h0000, row_drive_o.hiz}, 16'h0001, "rows wait for supply");
    wait_status(lcd_timing_pkg::SEQ_ACTIVE, 2400);
    repeat (2) @(posedge clk_i);
    check({13'h0000, row_drive_o.hiz, col_gnd_o, analog_o.pump_on}, 16'h0001,
          "drivers on");
    $display("Power-up test done");
    wr_reg(lcd_timing_pkg::ADDR_DISP_START, 16'h0000);
    wr_reg(lcd_timing_pkg::ADDR_DISP_END, 16'h007f);
    for (int c = 0; c < 4; c++) begin
      wr_reg(lcd_timing_pkg::ADDR_PANEL_CTRL, 16'h0300 | 16'(c << 3));
      wait_tick(n);
      wait_tick(n);
      check(16'(n), {4'h0, per_exp[c]}, "line period");
    end
    wr_reg(lcd_timing_pkg::ADDR_DISP_END, 16'h0003);
    wait_tick(n);
    wait_tick(n);
    check(16'(n), {4'h0, per_exp[3]} * 16'h0004, "scaled line period");
    $display("Line rate test done");
    for (int k = 0; k < 4; k++) begin
      fill <= ovr_fill[k];
      wr_reg(lcd_timing_pkg::ADDR_DISP_CTRL, {13'h0000, ovr_disp[k]});
      wait_tick(n);
      wait_tick(n);
      check({14'h0000, col_level_o}, {14'h0000, ovr_exp[k]}, "column level");
    end
    wr_reg(lcd_timing_pkg::ADDR_DISP_CTRL, 16'h0003);
    repeat (2) @(posedge clk_i);
    check({11'h000, col_gnd_o, row_drive_o.hiz, analog_o.sleep, col_level_o}, 16'h001c,
          "disabled drivers");
    check({8'h00, panel_faults}, 16'h0000, "panel electrode faults");
    $display("Override test done");
    complete_run();
  end
endmodule // lcd_display_control_timing_bench
`default_nettype wire
